/* File: core/sdbg_port.sv */
// Debug port: commands, memory access, background mode
`timescale 1ns/1ps
// Notes on behaviour
// RL1 - Host opens every bit with a falling edge.
// RL2 - MSB first, sixteen bus cycles per bit.
// RL3 - 512 cycles between host edges clears the command.
// RL4 - Edge seen within a cycle; host bit sampled at ten.
// RL5 - Host holds the wire low two cycles, then releases.
// RL6 - A sent one gets a high pulse at count seven.
// RL7 - Host samples a sent bit near count ten.
// RL8 - A sent zero is low thirteen cycles, then briefly high.
// RL9 - In-map byte write to FF01 sets the unlock bit.
// RL10 - Active mode maps debug registers and ROM at FF00-FFFF.
// RL11 - Command, tag or halt enter background; ignored while locked.
// RL12 - Command entry waits for a boundary; tags enter at once.
// RL13 - Special single-chip mode leaves reset enabled and active.
// RL14 - Eight-bit opcode, then address and/or data.
// RL15 - Host waits 150 cycles after a command or address.
// RL16 - Debug holds the bus; multi-cycle accesses freeze the CPU.
// RL17 - Wait for a free cycle, steal one after 128.
// RL18 - Opcode 90 enters background only when unlocked.
// RL19 - E4 and EC read in map; odd low, even high.
// RL20 - E0 and E8 read out of map, same lanes.
// RL21 - C4 writes a byte in map; odd low, even high.
// RL22 - Status reads 00, 80 when halt allowed, C0 when active.
// RL23 - Host unlocks by read, set MSB, write back status.
// RL24 - C8 writes an aligned word out of map.
// RL25 - Every read returns sixteen bits.
// RL26 - Timeout drops a partial command; next edge starts an opcode.
module sdbg_port (
   input  wire logic        core_clk_in,
   input  wire logic        reset_n_in,
   input  wire logic        debug_wire_pin_in,
   output logic             debug_wire_pin_out,
   output logic             debug_wire_pin_oe_out,
   input  wire logic        cpu_free_cycle_in,
   input  wire logic        mem_ready_in,
   input  wire logic [15:0] mem_rdata_in,
   output logic             mem_req_out,
   output logic             mem_we_out,
   output logic [15:0]      mem_addr_out,
   output logic [15:0]      mem_wdata_out,
   output logic [1:0]       mem_be_out,
   output logic             mem_debug_map_out,
   output logic             cpu_freeze_out,
   input  wire logic        instr_boundary_in,
   input  wire logic        tag_hit_in,
   input  wire logic        halt_to_debug_instr_in,
   input  wire logic        bg_exit_in,
   input  wire logic        special_chip_mode_in,
   output logic             background_active_out,
   output logic             firmware_unlock_out
);
   import sdbg_pkg::*;

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      sdbg_state_type    st;
      logic [7:0]        opcode;
      logic [15:0]       addr;
      logic [15:0]       data;
      logic [CNT_W-1:0]  bits;
      logic [WAIT_W-1:0] wait_cnt;
      logic              is_read;
      logic              unlock;
      logic              active;
      logic              bg_pend;
      logic              started;
      logic              mem_req;
      logic              freeze;
   } sdbg_ctl_type;

   sdbg_ctl_type r_q;
   sdbg_ctl_type r_d;

   logic       in_map;
   logic       is_word;
   logic       status_hit;
   logic [7:0] status_byte;
   logic [7:0] opc_next;

   sdbg_bit_if bit_if ();

   // ----------------------------------------------------------------
   // Wire timing engine
   // ----------------------------------------------------------------
   sdbg_bit_engine u_engine (
      .core_clk_in       (core_clk_in),
      .reset_n_in        (reset_n_in),
      .debug_wire_pin_in (debug_wire_pin_in),
      .pin_out           (debug_wire_pin_out),
      .pin_oe_out        (debug_wire_pin_oe_out),
      .bit_if            (bit_if.engine)
   );

   // Next bit to send, MSB first
   assign bit_if.tx_en  = (r_q.st == S_RDATA);
   assign bit_if.tx_bit = r_q.data[WORD_LEN-1];          // [RL2]

   // ----------------------------------------------------------------
   // Command decode helpers
   // ----------------------------------------------------------------
   assign in_map = (r_q.opcode == OP_RD_OCTET_MAP) ||
                   (r_q.opcode == OP_RD_PAIR_MAP)  ||
                   (r_q.opcode == OP_WR_OCTET_MAP) ||
                   (r_q.opcode == OP_WR_PAIR_MAP);
   assign is_word = (r_q.opcode == OP_RD_PAIR_MAP)  ||
                    (r_q.opcode == OP_RD_PAIR)      ||
                    (r_q.opcode == OP_WR_PAIR_MAP)  ||
                    (r_q.opcode == OP_WR_PAIR);
   // In-map byte access to the status address stays local
   assign status_hit = in_map && !is_word && (r_q.addr == STATUS_ADDR); // [RL9]
   assign opc_next   = {r_q.opcode[6:0], bit_if.rx_bit};

   // Status byte: 00 running, 80 halt allowed, C0 active
   always_comb begin
      status_byte                  = STATUS_RESET;
      status_byte[STAT_UNLOCK_BIT] = r_q.unlock;             // [RL22]
      status_byte[STAT_ACTIVE_BIT] = r_q.active;
   end

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      r_d = r_q;

      // Strap caught on the first edge after reset release
      if (!r_q.started) begin
         r_d.started = 1'b1;
         if (special_chip_mode_in) begin
            r_d.unlock = 1'b1;                               // [RL13]
            r_d.active = 1'b1;
         end
      end

      // Background entry and exit
      if (r_q.active) begin
         r_d.bg_pend = 1'b0;
         if (bg_exit_in) begin
            r_d.active = 1'b0;
         end
      end else if (r_q.unlock) begin
         if (tag_hit_in || halt_to_debug_instr_in) begin
            r_d.active = 1'b1;                               // [RL11] [RL12]
         end else if (r_q.bg_pend && instr_boundary_in) begin
            r_d.active  = 1'b1;                              // [RL12]
            r_d.bg_pend = 1'b0;
         end
      end

      case (r_q.st)
         // Opcode, MSB first
         S_OPC: begin
            if (bit_if.rx_valid) begin
               r_d.opcode = opc_next;                        // [RL14]
               r_d.bits   = r_q.bits + CNT_W'(1);
               if (r_q.bits == CNT_W'(OP_LEN - 1)) begin
                  r_d.bits = '0;
                  case (opc_next)
                     OP_BACKGROUND: begin
                        // Dropped unless firmware is enabled
                        r_d.bg_pend = r_q.unlock & ~r_q.active; // [RL18] [RL11]
                     end
                     OP_RD_OCTET_MAP, OP_RD_PAIR_MAP,
                     OP_RD_OCTET, OP_RD_PAIR: begin
                        r_d.is_read = 1'b1;                  // [RL19] [RL20]
                        r_d.st      = S_ADDR;
                     end
                     OP_WR_OCTET_MAP, OP_WR_PAIR_MAP,
                     OP_WR_OCTET, OP_WR_PAIR: begin
                        r_d.is_read = 1'b0;                  // [RL21] [RL24]
                        r_d.st      = S_ADDR;
                     end
                     default: begin
                        r_d.st = S_OPC;
                     end
                  endcase
               end
            end
         end

         // 16-bit address
         S_ADDR: begin
            if (bit_if.rx_valid) begin
               r_d.addr = {r_q.addr[14:0], bit_if.rx_bit};
               r_d.bits = r_q.bits + CNT_W'(1);
               if (r_q.bits == CNT_W'(WORD_LEN - 1)) begin
                  r_d.bits     = '0;
                  r_d.wait_cnt = '0;
                  r_d.st       = r_q.is_read ? S_WAIT : S_WDATA;
               end
            end
         end

         // 16-bit write data
         S_WDATA: begin
            if (bit_if.rx_valid) begin
               r_d.data = {r_q.data[14:0], bit_if.rx_bit};
               r_d.bits = r_q.bits + CNT_W'(1);
               if (r_q.bits == CNT_W'(WORD_LEN - 1)) begin
                  r_d.bits     = '0;
                  r_d.wait_cnt = '0;
                  r_d.st       = S_WAIT;
               end
            end
         end

         // Look for a free bus cycle, steal one after the limit
         S_WAIT: begin
            if (status_hit) begin
               if (r_q.is_read) begin
                  r_d.data = {8'h00, status_byte};           // [RL22] [RL25]
                  r_d.st   = S_RDATA;
               end else begin
                  r_d.unlock = r_q.data[STAT_UNLOCK_BIT];    // [RL9]
                  r_d.st     = S_OPC;
               end
            end else if (cpu_free_cycle_in) begin
               r_d.mem_req = 1'b1;                           // [RL17]
               r_d.st      = S_RUN;
            end else if (r_q.wait_cnt == WAIT_W'(STEAL_CYC - 1)) begin
               r_d.mem_req = 1'b1;
               r_d.freeze  = 1'b1;                           // [RL17]
               r_d.st      = S_RUN;
            end else begin
               r_d.wait_cnt = r_q.wait_cnt + WAIT_W'(1);
            end
         end

         // Hold the bus until the access completes
         S_RUN: begin
            if (mem_ready_in) begin
               r_d.mem_req = 1'b0;                           // [RL16]
               r_d.freeze  = 1'b0;
               if (r_q.is_read) begin
                  r_d.data = mem_rdata_in;                   // [RL25]
                  r_d.st   = S_RDATA;
               end else begin
                  r_d.st = S_OPC;
               end
            end else begin
               r_d.freeze = 1'b1;                            // [RL16]
            end
         end

         // 16 read bits back to the host, MSB first
         S_RDATA: begin
            if (bit_if.tx_done) begin
               r_d.data = {r_q.data[14:0], 1'b0};            // [RL2]
               r_d.bits = r_q.bits + CNT_W'(1);
               if (r_q.bits == CNT_W'(WORD_LEN - 1)) begin
                  r_d.bits = '0;                             // [RL25]
                  r_d.st   = S_OPC;
               end
            end
         end

         default: begin
            r_d.st = S_OPC;
         end
      endcase

      // Timeout clears the command, not a bus access
      if (bit_if.timeout && (r_q.st != S_WAIT) && (r_q.st != S_RUN)) begin
         r_d.st     = S_OPC;                                 // [RL26]
         r_d.bits   = '0;
         r_d.opcode = OP_CLEAR;                              // [RL3]
      end
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         r_q        <= '0;
         r_q.st     <= S_OPC;
         r_q.opcode <= OP_CLEAR;
      end else begin
         r_q <= r_d;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   // Byte lanes: odd address low byte, even address high byte
   assign mem_be_out[1] = is_word | ~r_q.addr[0];            // [RL19] [RL21]
   assign mem_be_out[0] = is_word | r_q.addr[0];
   assign mem_req_out   = r_q.mem_req;
   assign mem_we_out    = r_q.mem_req & ~r_q.is_read;
   assign mem_addr_out  = r_q.addr;
   assign mem_wdata_out = r_q.data;
   // In-map commands see the debug map; active mode maps it too
   assign mem_debug_map_out     = in_map | r_q.active;       // [RL10] [RL20]
   assign cpu_freeze_out        = r_q.freeze;
   assign background_active_out = r_q.active;                // [RL10]
   assign firmware_unlock_out   = r_q.unlock;

endmodule : sdbg_port

/* File: core/sdbg_pkg.sv */
// Constants and types shared by the single-wire debug port
package sdbg_pkg;

   // ----------------------------------------------------------------
   // Bit timing, in bus-clock cycles
   // ----------------------------------------------------------------
   localparam int BIT_CYCLES  = 16;  // Nominal bit period
   localparam int SAMPLE_AT   = 10;  // Host bit sampled here
   localparam int SPEEDUP_AT  = 7;   // Speed-up pulse for a one
   localparam int ZERO_LOW    = 13;  // Low time for a sent zero
   localparam int TIMEOUT_CYC = 512; // Gap between host edges
   localparam int STEAL_CYC   = 128; // Wait for a free bus cycle
   localparam int CNT_W       = 5;
   localparam int IDLE_W      = 10;
   localparam int WAIT_W      = 8;

   // ----------------------------------------------------------------
   // Frame lengths
   // ----------------------------------------------------------------
   localparam int OP_LEN   = 8;
   localparam int WORD_LEN = 16;

   // ----------------------------------------------------------------
   // Hardware command opcodes
   // ----------------------------------------------------------------
   localparam logic [7:0] OP_BACKGROUND   = 8'h90;
   localparam logic [7:0] OP_RD_OCTET_MAP = 8'hE4;
   localparam logic [7:0] OP_RD_PAIR_MAP  = 8'hEC;
   localparam logic [7:0] OP_RD_OCTET     = 8'hE0;
   localparam logic [7:0] OP_RD_PAIR      = 8'hE8;
   localparam logic [7:0] OP_WR_OCTET_MAP = 8'hC4;
   localparam logic [7:0] OP_WR_PAIR_MAP  = 8'hCC;
   localparam logic [7:0] OP_WR_OCTET     = 8'hC0;
   localparam logic [7:0] OP_WR_PAIR      = 8'hC8;
   localparam logic [7:0] OP_CLEAR        = 8'h00;

   // ----------------------------------------------------------------
   // Debug state register
   // ----------------------------------------------------------------
   localparam logic [15:0] STATUS_ADDR     = 16'hFF01;
   localparam logic [7:0]  STATUS_RESET    = 8'h00;
   localparam int          STAT_UNLOCK_BIT = 7;
   localparam int          STAT_ACTIVE_BIT = 6;

   // Command sequencer states
   typedef enum logic [2:0] {
      S_OPC,
      S_ADDR,
      S_WDATA,
      S_WAIT,
      S_RUN,
      S_RDATA
   } sdbg_state_type;

endpackage : sdbg_pkg

/* File: core/sdbg_bit_if.sv */
// Link between wire engine and command sequencer
`timescale 1ns/1ps
interface sdbg_bit_if;
   logic tx_en;     // Next bit is sent by the device
   logic tx_bit;    // Level of the bit to send
   logic rx_valid;  // One-cycle pulse: host bit sampled
   logic rx_bit;    // Sampled host bit
   logic tx_done;   // One-cycle pulse: sent bit taken by host
   logic timeout;   // One-cycle pulse: host edge gap expired

   modport engine (
      input  tx_en,
      input  tx_bit,
      output rx_valid,
      output rx_bit,
      output tx_done,
      output timeout
   );

   modport ctrl (
      output tx_en,
      output tx_bit,
      input  rx_valid,
      input  rx_bit,
      input  tx_done,
      input  timeout
   );
endinterface : sdbg_bit_if

/* File: core/sdbg_bit_engine.sv */
// Wire timing engine: edges, bit timing, gap timeout
`timescale 1ns/1ps
module sdbg_bit_engine
   import sdbg_pkg::*;
(
   input  wire logic    core_clk_in,
   input  wire logic    reset_n_in,
   input  wire logic    debug_wire_pin_in,
   output logic         pin_out,
   output logic         pin_oe_out,
   sdbg_bit_if.engine   bit_if
);

   typedef struct packed {
      logic              pin_prev;
      logic              run;
      logic [CNT_W-1:0]  cnt;
      logic [IDLE_W-1:0] idle;
      logic              tx_on;
      logic              tx_val;
      logic              drv_oe;
      logic              drv_val;
      logic              rx_valid;
      logic              rx_bit;
      logic              tx_done;
      logic              timeout;
   } sdbg_eng_type;

   sdbg_eng_type r_q;
   sdbg_eng_type r_d;
   logic         fall;

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      r_d          = r_q;
      r_d.rx_valid = 1'b0;
      r_d.tx_done  = 1'b0;
      r_d.timeout  = 1'b0;
      r_d.pin_prev = debug_wire_pin_in;
      // Host falling edge; own drive never counts as one
      fall = r_q.pin_prev & ~debug_wire_pin_in & ~r_q.drv_oe;
      if (fall) begin
         // Edge cycle is count 0 of the bit
         r_d.run     = 1'b1;                             // [RL4]
         r_d.cnt     = CNT_W'(1);
         r_d.idle    = '0;                               // [RL3]
         r_d.tx_on   = bit_if.tx_en;
         r_d.tx_val  = bit_if.tx_bit;
         r_d.drv_oe  = bit_if.tx_en & ~bit_if.tx_bit;    // [RL8]
         r_d.drv_val = 1'b0;
      end else begin
         // Gap timer saturates after one timeout pulse
         if (r_q.idle != IDLE_W'(TIMEOUT_CYC - 1)) begin
            r_d.idle = r_q.idle + IDLE_W'(1);
            if (r_q.idle == IDLE_W'(TIMEOUT_CYC - 2)) begin
               r_d.timeout = 1'b1;                       // [RL3]
            end
         end
         if (r_q.run) begin
            r_d.cnt = r_q.cnt + CNT_W'(1);
            if (r_q.tx_on && !r_q.tx_val) begin
               // Low until count 12, one high cycle at 13
               if (r_q.cnt == CNT_W'(ZERO_LOW - 1)) begin
                  r_d.drv_val = 1'b1;                    // [RL8]
               end
               if (r_q.cnt == CNT_W'(ZERO_LOW)) begin
                  r_d.drv_oe = 1'b0;
               end
            end
            if (r_q.tx_on && r_q.tx_val) begin
               // One-cycle high pulse at count 7
               if (r_q.cnt == CNT_W'(SPEEDUP_AT - 1)) begin
                  r_d.drv_oe  = 1'b1;                    // [RL6]
                  r_d.drv_val = 1'b1;
               end
               if (r_q.cnt == CNT_W'(SPEEDUP_AT)) begin
                  r_d.drv_oe = 1'b0;
               end
            end
            if (r_q.cnt == CNT_W'(SAMPLE_AT)) begin
               r_d.tx_done  = r_q.tx_on;
               r_d.rx_valid = ~r_q.tx_on;                // [RL4]
               r_d.rx_bit   = debug_wire_pin_in;
            end
            if (r_q.cnt == CNT_W'(BIT_CYCLES - 1)) begin
               r_d.run = 1'b0;                           // [RL2]
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         r_q          <= '0;
         r_q.pin_prev <= 1'b1; // Idle wire is high
      end else begin
         r_q <= r_d;
      end
   end

   // Outputs straight from flops
   assign pin_out         = r_q.drv_val;
   assign pin_oe_out      = r_q.drv_oe;
   assign bit_if.rx_valid = r_q.rx_valid;
   assign bit_if.rx_bit   = r_q.rx_bit;
   assign bit_if.tx_done  = r_q.tx_done;
   assign bit_if.timeout  = r_q.timeout;

endmodule : sdbg_bit_engine

/* File: verif/sdbg_port_assertions.sv */
// Concurrent checks on the debug port pins
`timescale 1ns/1ps
module sdbg_port_assertions (
   input wire logic        core_clk_in,
   input wire logic        reset_n_in,
   input wire logic        debug_wire_pin_in,
   input wire logic        debug_wire_pin_out,
   input wire logic        debug_wire_pin_oe_out,
   input wire logic        cpu_free_cycle_in,
   input wire logic        mem_ready_in,
   input wire logic        mem_req_out,
   input wire logic [15:0] mem_addr_out,
   input wire logic [15:0] mem_wdata_out,
   input wire logic        mem_debug_map_out,
   input wire logic        cpu_freeze_out,
   input wire logic        tag_hit_in,
   input wire logic        bg_exit_in,
   input wire logic        special_chip_mode_in,
   input wire logic        background_active_out,
   input wire logic        firmware_unlock_out
);
   // ---------------------------------------------
   // Checks, all on the bus clock
   // ---------------------------------------------
   wire drv_oe  = debug_wire_pin_oe_out;
   wire drv_lvl = debug_wire_pin_out;
   wire pin_lvl = debug_wire_pin_in;
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (!reset_n_in);
   a_zero_span: assert property (
      $rose(drv_oe) && !drv_lvl |->
      ##11 (drv_oe && !drv_lvl) ##1 (drv_oe && drv_lvl) ##1 !drv_oe)
      else $error("zero span");
   a_one_pulse: assert property (
      $rose(drv_oe) && drv_lvl |=> !drv_oe)
      else $error("one pulse too long");
   a_one_seven: assert property (
      $rose(drv_oe) && drv_lvl |-> !$past(pin_lvl, 7) && $past(pin_lvl, 8))
      else $error("one pulse late");
   a_req_hold: assert property (
      mem_req_out && !mem_ready_in |=>
      mem_req_out && $stable(mem_addr_out) && $stable(mem_wdata_out))
      else $error("access moved early");
   a_req_release: assert property (
      mem_req_out && mem_ready_in |=> !mem_req_out)
      else $error("request held");
   a_steal_freeze: assert property (
      $rose(mem_req_out) && !$past(cpu_free_cycle_in) |-> cpu_freeze_out)
      else $error("steal without freeze");
   a_freeze_owner: assert property (
      cpu_freeze_out |-> mem_req_out)
      else $error("freeze without access");
   a_active_map: assert property (
      mem_req_out && background_active_out |-> mem_debug_map_out)
      else $error("map absent");
   a_tag_entry: assert property (
      tag_hit_in && firmware_unlock_out && !bg_exit_in |=> background_active_out)
      else $error("tag missed");
   a_locked_idle: assert property (
      !special_chip_mode_in && !firmware_unlock_out && !background_active_out
      |=> !background_active_out)
      else $error("entered while locked");
endmodule : sdbg_port_assertions

/* File: verif/sdbg_host_model.sv */
// Host development system model driving the debug wire
`timescale 1ns/1ps
module sdbg_host_model (
   input  wire logic core_clk_in,
   input  wire logic wire_in,
   output logic      host_low_out
);
   initial host_low_out = 1'b0;
   // Host-to-device bits, MSB first
   task automatic tx(input logic [15:0] v, input int n);
      for (int i = n - 1; i >= 0; i--) begin
         @(posedge core_clk_in) host_low_out <= 1'b1;
         repeat (v[i] ? 4 : 13) @(posedge core_clk_in);
         host_low_out <= 1'b0;
         repeat (v[i] ? 13 : 4) @(posedge core_clk_in);
      end
   endtask : tx
   // Device-to-host bits, sampled at ten
   task automatic rx(output logic [15:0] v);
      for (int i = 0; i < 16; i++) begin
         @(posedge core_clk_in) host_low_out <= 1'b1;
         repeat (2) @(posedge core_clk_in);
         host_low_out <= 1'b0;
         repeat (8) @(posedge core_clk_in);
         v = {v[14:0], wire_in};
         repeat (6) @(posedge core_clk_in);
      end
   endtask : rx
endmodule : sdbg_host_model

/* File: verif/sdbg_port_test.sv */
// Self-checking bench for the single-wire debug port
`timescale 1ns/1ps
module sdbg_port_test;
   logic        core_clk_in = 1'b0, reset_n_in = 1'b0, free = 1'b0, ready = 1'b0;
   logic        bound = 1'b0, tag = 1'b0, halt = 1'b0, bexit = 1'b0, special = 1'b0;
   logic        host_low, pin_o, pin_oe, req, we, map, freeze, active, unlock;
   logic [15:0] rdata = 16'h0000, addr, wdata, rd;
   logic [1:0]  be;
   logic [35:0] wr = '0;
   int          failures = 0, check_count = 0, cycles = 0;
   wire         pin = ~host_low & ~(pin_oe & ~pin_o); // Pulled up when released
   // ---------------------------------------------
   // Clock, host, design and memory
   // ---------------------------------------------
   always #2.5 core_clk_in = ~core_clk_in;
   sdbg_host_model host (.core_clk_in(core_clk_in), .wire_in(pin), .host_low_out(host_low));
   sdbg_port uut (.core_clk_in(core_clk_in), .reset_n_in(reset_n_in),
      .debug_wire_pin_in(pin), .debug_wire_pin_out(pin_o), .debug_wire_pin_oe_out(pin_oe),
      .cpu_free_cycle_in(free), .mem_ready_in(ready), .mem_rdata_in(rdata),
      .mem_req_out(req), .mem_we_out(we), .mem_addr_out(addr), .mem_wdata_out(wdata),
      .mem_be_out(be), .mem_debug_map_out(map), .cpu_freeze_out(freeze),
      .instr_boundary_in(bound), .tag_hit_in(tag), .halt_to_debug_instr_in(halt),
      .bg_exit_in(bexit), .special_chip_mode_in(special),
      .background_active_out(active), .firmware_unlock_out(unlock));
   // Memory answers one cycle late, records writes
   always @(posedge core_clk_in) begin
      ready <= req & ~ready;
      rdata <= addr ^ 16'h5A5A;
      if (req && ready) wr <= {map, we, be, addr, wdata};
      cycles <= cycles + 1;
      if (cycles == 40000) begin
         failures++;
         finish_test();
      end
   end
   // ---------------------------------------------
   // Helpers
   // ---------------------------------------------
   task automatic wt(input int n);
      repeat (n) @(posedge core_clk_in);
   endtask : wt
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      check_count++;
      if (g !== e) begin
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
         failures++;
      end
   endtask : chk
   task automatic rd_cmd(input logic [7:0] op, input logic [15:0] a, output logic [15:0] v);
      host.tx({8'h00, op}, 8);
      host.tx(a, 16);
      wt(150);
      host.rx(v);
   endtask : rd_cmd
   task automatic wr_cmd(input logic [7:0] op, input logic [15:0] a, input logic [15:0] d);
      host.tx({8'h00, op}, 8);
      host.tx(a, 16);
      host.tx(d, 16);
      wt(150);
   endtask : wr_cmd
   task automatic pulse_chk(input string nm, input bit use_tag);
      tag <= use_tag;
      halt <= !use_tag;
      wt(1);
      {tag, halt} <= 2'b00;
      wt(1);
      chk(nm, 16'h0001, {15'h0, active});
      bexit <= 1'b1;
      wt(1);
      bexit <= 1'b0;
      wt(1);
      chk("exit", 16'h0000, {15'h0, active});
   endtask : pulse_chk
   // ---------------------------------------------
   // Scenarios
   // ---------------------------------------------
   task automatic t_status;
      bound <= 1'b1;
      host.tx(16'h0090, 8);
      wt(20);
      chk("locked entry", 16'h0000, {15'h0, active});
      rd_cmd(8'hE4, 16'hFF01, rd);
      chk("status idle", 16'h0000, rd);
      wr_cmd(8'hC4, 16'hFF01, 16'h0080);
      rd_cmd(8'hE4, 16'hFF01, rd);
      chk("status unlocked", 16'h0080, rd);
      chk("unlock pin", 16'h0001, {15'h0, unlock});
   endtask : t_status
   task automatic t_background;
      host.tx(16'h0090, 8);
      wt(4);
      chk("entered", 16'h0001, {15'h0, active});
      rd_cmd(8'hE4, 16'hFF01, rd);
      chk("status active", 16'h00C0, rd);
      rd_cmd(8'hE0, 16'h4446, rd);
      chk("active read", 16'h1E1C, rd);
      bexit <= 1'b1;
      wt(1);
      bexit <= 1'b0;
      pulse_chk("tag entry", 1'b1);
      pulse_chk("halt entry", 1'b0);
   endtask : t_background
   task automatic t_mem_read;
      logic [7:0]  ops[3] = '{8'hE0, 8'hE8, 8'hEC};
      logic [15:0] adr[3] = '{16'h1235, 16'h2468, 16'h3000};
      for (int i = 0; i < 3; i++) begin
         free <= (i == 1);
         rd_cmd(ops[i], adr[i], rd);
         chk("read data", adr[i] ^ 16'h5A5A, rd);
      end
      free <= 1'b0;
   endtask : t_mem_read
   task automatic t_mem_write;
      wr_cmd(8'hC8, 16'h2000, 16'hBEEF);
      chk("word write", 16'hBEEF, wr[15:0]);
      chk("word addr", 16'h2000, wr[31:16]);
      chk("word lanes", 16'h0007, {12'h0, wr[35:32]});
      wr_cmd(8'hC4, 16'h0102, 16'h3C00);
      chk("even lane", 16'h000E, {12'h0, wr[35:32]});
      wr_cmd(8'hC4, 16'h0103, 16'h003C);
      chk("odd lane", 16'h000D, {12'h0, wr[35:32]});
   endtask : t_mem_write
   task automatic t_timeout;
      host.tx(16'h000E, 4);
      wt(600);
      rd_cmd(8'hE4, 16'hFF01, rd);
      chk("after timeout", 16'h0080, rd);
   endtask : t_timeout
   task automatic finish_test;
      $display("failures=%0d check_count=%0d", failures, check_count);
      if (failures == 0 && check_count > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : finish_test
   // Main sequence
   initial begin
      wt(16);
      reset_n_in <= 1'b1;
      wt(2);
      t_status();
      t_background();
      t_mem_read();
      t_mem_write();
      t_timeout();
      special <= 1'b1;
      reset_n_in <= 1'b0;
      wt(16);
      reset_n_in <= 1'b1;
      wt(3);
      chk("strap state", 16'h0003, {14'h0, unlock, active});
      finish_test();
   end
endmodule : sdbg_port_test
bind sdbg_port sdbg_port_assertions chk_i (.core_clk_in, .reset_n_in, .debug_wire_pin_in,
   .debug_wire_pin_out, .debug_wire_pin_oe_out, .cpu_free_cycle_in, .mem_ready_in,
   .mem_req_out, .mem_addr_out, .mem_wdata_out, .mem_debug_map_out, .cpu_freeze_out,
   .tag_hit_in, .bg_exit_in, .special_chip_mode_in, .background_active_out,
   .firmware_unlock_out);
